// file: lmc_pkg.sv
// Constants, field layouts and types for the per-link mode configuration bank
package lmc_pkg;

  // Host port widths and address split: link index above, register offset below
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 8;
  localparam int OFF_W    = 8;
  localparam int LINK_W   = 3;
  localparam int MAX_LINK = 8;

  // Register offsets within one link's 0x100 window
  localparam logic [7:0] MODE_OFF = 8'h20;
  localparam logic [7:0] TERM_OFF = 8'h32;
  localparam logic [7:0] SYS_OFF  = 8'h40;
  localparam logic [7:0] TEST_OFF = 8'h41;

  // Mode register fields
  localparam int FMT_LSB    = 0;
  localparam int REGION_BIT = 2;
  localparam int TRUNK_BIT  = 3;
  localparam logic [7:0] MODE_MASK = 8'h0F;

  // Termination register fields
  localparam int TERM_EXT_BIT = 2;
  localparam logic [7:0] TERM_MASK = 8'h07;

  // System interface register fields
  localparam int SYS_RATE_BIT = 0;
  localparam int SYS_MUX_BIT  = 1;
  localparam logic [7:0] SYS_MASK = 8'h03;

  // Test register fields
  localparam int TST_UNFR_BIT = 0;
  localparam int TST_AMI_BIT  = 1;
  localparam int TST_BPV_BIT  = 2;
  localparam int TST_PRBS_BIT = 3;
  localparam int TST_PDIR_BIT = 4;
  localparam int TST_LB_LSB   = 5;
  localparam logic [7:0] TEST_MASK = 8'hFF;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] TERM_RST = 8'h00;
  localparam logic [7:0] SYS_RST  = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;

  // Loopback selections; code 7 is reserved and acts as none
  localparam logic [2:0] LB_NONE    = 3'h0;
  localparam logic [2:0] LB_SYSTEM  = 3'h6;

  // HDLC channel counts
  localparam logic [1:0] HDLC_FULL  = 2'h3;
  localparam logic [1:0] HDLC_SHORT = 2'h2;

  // Trunk standard, framing format and line code
  typedef enum logic [1:0] {STD_E1, STD_T1, STD_J1} lmc_std_e;
  typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC96} lmc_fmt_e;
  typedef enum logic [1:0] {CODE_AMI, CODE_B8ZS, CODE_HDB3} lmc_code_e;

endpackage

// file: lmc_link_mode_config.sv
// Per-link mode configuration register bank with host port and decoded controls
//
// What this block does
// - Each link configured independently, three standards
// - North American: codes pick SF, ESF, DM, SLC-96
// - Japanese variant allows only SF and ESF
// - Standard select zero: European, other fields ignored
// - Mode register at 0x020 plus 0x100 per link
// - Termination MSB zero enables internal matching
// - Low bits pick 75, 120, 100, 110 ohm
// - Termination MSB one disables internal matching
// - Optional 1.544 to 2.048 rate conversion
// - Two sets of four links, two buses; here each link picks its bus by its own mux bit, no fixed sets
// - European mode: four links per system bus; not enforced, each link's own mux bit works alike in every standard
// - Unframed setting passes payload without framing
// - Three HDLC in ESF/DM, two in SF/SLC-96
// - European mode offers three HDLC channels
// - AMI or B8ZS; HDB3 in European mode
// - Violation insertion only with AMI coding
// - PRBS generated one way, checked opposite way
// - Six diagnostic loopback modes selectable
`timescale 1ns/1ps
`default_nettype none

module lmc_link_mode_config #(
  parameter int NLINK = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 host_cs_n,
  input  wire logic                 host_wr_n,
  input  wire logic                 host_rd_n,
  input  wire logic [10:0]          host_addr,
  input  wire logic [7:0]           host_wdata,
  output logic      [7:0]           host_rdata,
  output logic                      host_rdata_oe,
  output logic      [2*NLINK-1:0]   link_std,
  output logic      [2*NLINK-1:0]   link_fmt,
  output logic      [NLINK-1:0]     link_unframed,
  output logic      [2*NLINK-1:0]   link_hdlc_cnt,
  output logic      [2*NLINK-1:0]   link_line_code,
  output logic      [NLINK-1:0]     link_bpv_en,
  output logic      [NLINK-1:0]     link_prbs_en,
  output logic      [NLINK-1:0]     link_prbs_dir,
  output logic      [3*NLINK-1:0]   link_loopback,
  output logic      [NLINK-1:0]     link_term_int_en,
  output logic      [2*NLINK-1:0]   link_term_sel,
  output logic      [NLINK-1:0]     link_rate_conv,
  output logic      [NLINK-1:0]     link_bus_mux
);

  localparam int SYNC_W = 3 + lmc_pkg::ADDR_W + lmc_pkg::DATA_W;

  // Refuse link counts the address split cannot reach
  if (NLINK < 1 || NLINK > lmc_pkg::MAX_LINK) begin : g_bad_nlink
    $error("NLINK must be 1 to 8");
  end

  // Host pin synchroniser stages
  logic [SYNC_W-1:0]         sync1_reg;   // First stage, read only by second
  logic [SYNC_W-1:0]         sync2_reg;   // Second stage, safe to use
  logic                      wr_prev_reg; // Previous write-active level
  logic                      cs_n_s;      // Synchronised chip select
  logic                      wr_n_s;      // Synchronised write strobe
  logic                      rd_n_s;      // Synchronised read strobe
  logic [10:0]               addr_s;      // Synchronised address
  logic [7:0]                wdata_s;     // Synchronised write data
  logic                      wr_act;      // Write strobe active
  logic                      rd_act;      // Read strobe active
  logic                      wr_pulse;    // One cycle per host write
  logic [2:0]                addr_link;   // Link index field
  logic [7:0]                addr_off;    // Offset within link window

  // Per-link stored registers
  logic [7:0]                mode_q [NLINK];
  logic [7:0]                term_q [NLINK];
  logic [7:0]                sys_q  [NLINK];
  logic [7:0]                test_q [NLINK];
  logic [7:0]                rdata_next;  // Read mux result

  // Two flip-flops on every host pin before use
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= {SYNC_W{1'b1}};
      sync2_reg <= {SYNC_W{1'b1}};
    end else begin
      sync1_reg <= {host_cs_n, host_wr_n, host_rd_n, host_addr, host_wdata};
      sync2_reg <= sync1_reg;
    end
  end

  assign {cs_n_s, wr_n_s, rd_n_s, addr_s, wdata_s} = sync2_reg;
  assign wr_act    = ~cs_n_s & ~wr_n_s;
  assign rd_act    = ~cs_n_s & ~rd_n_s;
  assign addr_link = addr_s[10:8];
  assign addr_off  = addr_s[7:0];

  // Edge detect so a held strobe writes once
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_prev_reg <= 1'b0;
    end else begin
      wr_prev_reg <= wr_act;
    end
  end

  assign wr_pulse = wr_act & ~wr_prev_reg;

  // Per-link registers and decoded controls
  for (genvar i = 0; i < NLINK; i++) begin : g_link
    logic              sel;        // Write aimed at this link
    logic              mode_ok;    // Proposed mode is a legal combination
    logic              trunk;      // Stored standard select
    logic              region;     // Stored region select
    logic [1:0]        fmt_code;   // Stored frame format code
    lmc_pkg::lmc_std_e std_d;      // Decoded standard
    lmc_pkg::lmc_fmt_e fmt_d;      // Decoded format
    lmc_pkg::lmc_code_e code_d;    // Decoded line code
    logic [1:0]        hdlc_d;     // HDLC channel count
    logic [2:0]        lb_d;       // Loopback selection
    logic              t1j1;       // Any 1.5 Mbit/s standard

    assign sel = wr_pulse && (addr_link == 3'(i));

    // Legal when European, or North American any format, or Japanese SF/ESF
    assign mode_ok = ~wdata_s[lmc_pkg::TRUNK_BIT]
                   | ~wdata_s[lmc_pkg::REGION_BIT]
                   | ~wdata_s[lmc_pkg::FMT_LSB+1];

    // Mode register: reserved combinations are dropped whole
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mode_q[i] <= lmc_pkg::MODE_RST;
      end else if (sel && addr_off == lmc_pkg::MODE_OFF && mode_ok) begin
        mode_q[i] <= wdata_s & lmc_pkg::MODE_MASK;
      end
    end

    // Termination register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        term_q[i] <= lmc_pkg::TERM_RST;
      end else if (sel && addr_off == lmc_pkg::TERM_OFF) begin
        term_q[i] <= wdata_s & lmc_pkg::TERM_MASK;
      end
    end

    // System interface register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sys_q[i] <= lmc_pkg::SYS_RST;
      end else if (sel && addr_off == lmc_pkg::SYS_OFF) begin
        sys_q[i] <= wdata_s & lmc_pkg::SYS_MASK;
      end
    end

    // Test and diagnostic register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        test_q[i] <= lmc_pkg::TEST_RST;
      end else if (sel && addr_off == lmc_pkg::TEST_OFF) begin
        test_q[i] <= wdata_s & lmc_pkg::TEST_MASK;
      end
    end

    assign trunk    = mode_q[i][lmc_pkg::TRUNK_BIT];
    assign region   = mode_q[i][lmc_pkg::REGION_BIT];
    assign fmt_code = mode_q[i][lmc_pkg::FMT_LSB+1:lmc_pkg::FMT_LSB];
    assign t1j1     = trunk;

    // Standard and framing decode
    always_comb begin
      std_d = lmc_pkg::STD_E1;
      fmt_d = lmc_pkg::FMT_SF;
      if (!trunk) begin
        // European: region and format are ignored
        std_d = lmc_pkg::STD_E1;
      end else if (!region) begin
        std_d = lmc_pkg::STD_T1;
        case (fmt_code)
          2'h0:    fmt_d = lmc_pkg::FMT_SF;
          2'h1:    fmt_d = lmc_pkg::FMT_ESF;
          2'h2:    fmt_d = lmc_pkg::FMT_DM;
          default: fmt_d = lmc_pkg::FMT_SLC96;
        endcase
      end else begin
        // Japanese: only SF and ESF can be stored
        std_d = lmc_pkg::STD_J1;
        fmt_d = fmt_code[0] ? lmc_pkg::FMT_ESF : lmc_pkg::FMT_SF;
      end
    end

    // Line code and HDLC channel decode
    always_comb begin
      if (!t1j1) begin
        code_d = lmc_pkg::CODE_HDB3;
        hdlc_d = lmc_pkg::HDLC_FULL;
      end else begin
        code_d = test_q[i][lmc_pkg::TST_AMI_BIT] ? lmc_pkg::CODE_AMI
                                                 : lmc_pkg::CODE_B8ZS;
        if (fmt_d == lmc_pkg::FMT_ESF || fmt_d == lmc_pkg::FMT_DM) begin
          hdlc_d = lmc_pkg::HDLC_FULL;
        end else begin
          hdlc_d = lmc_pkg::HDLC_SHORT;
        end
      end
    end

    // Loopback select, reserved code means none
    always_comb begin
      lb_d = test_q[i][lmc_pkg::TST_LB_LSB+2:lmc_pkg::TST_LB_LSB];
      if (lb_d > lmc_pkg::LB_SYSTEM) begin
        lb_d = lmc_pkg::LB_NONE;
      end
    end

    // Registered framing outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        link_std[2*i+:2]      <= 2'h0;
        link_fmt[2*i+:2]      <= 2'h0;
        link_unframed[i]      <= 1'b0;
        link_hdlc_cnt[2*i+:2] <= 2'h0;
      end else begin
        link_std[2*i+:2]      <= std_d;
        link_fmt[2*i+:2]      <= fmt_d;
        link_unframed[i]      <= test_q[i][lmc_pkg::TST_UNFR_BIT];
        link_hdlc_cnt[2*i+:2] <= hdlc_d;
      end
    end

    // Registered line coder and test outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        link_line_code[2*i+:2] <= 2'h0;
        link_bpv_en[i]         <= 1'b0;
        link_prbs_en[i]        <= 1'b0;
        link_prbs_dir[i]       <= 1'b0;
        link_loopback[3*i+:3]  <= 3'h0;
      end else begin
        link_line_code[2*i+:2] <= code_d;
        link_bpv_en[i]         <= test_q[i][lmc_pkg::TST_BPV_BIT]
                                  & (code_d == lmc_pkg::CODE_AMI);
        link_prbs_en[i]        <= test_q[i][lmc_pkg::TST_PRBS_BIT];
        link_prbs_dir[i]       <= test_q[i][lmc_pkg::TST_PDIR_BIT];
        link_loopback[3*i+:3]  <= lb_d;
      end
    end

    // Registered termination and system-side outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        link_term_int_en[i]   <= 1'b0;
        link_term_sel[2*i+:2] <= 2'h0;
        link_rate_conv[i]     <= 1'b0;
        link_bus_mux[i]       <= 1'b0;
      end else begin
        // MSB low enables internal matching, high hands it to external parts
        link_term_int_en[i]   <= ~term_q[i][lmc_pkg::TERM_EXT_BIT];
        // Low bits: 00 75 ohm, 01 120 ohm, 10 100 ohm, 11 110 ohm
        link_term_sel[2*i+:2] <= term_q[i][lmc_pkg::TERM_EXT_BIT]
                                 ? 2'h0 : term_q[i][1:0];
        // Rate conversion only applies to 1.5 Mbit/s streams
        link_rate_conv[i]     <= t1j1 & sys_q[i][lmc_pkg::SYS_RATE_BIT];
        // Each link picks its bus from its own system register mux bit, in every standard
        link_bus_mux[i]       <= sys_q[i][lmc_pkg::SYS_MUX_BIT];
      end
    end
  end

  // Read mux: address decode, unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (int'(addr_link) >= NLINK) begin
      rdata_next = 8'h00;
    end else if (addr_off == lmc_pkg::MODE_OFF) begin
      rdata_next = mode_q[addr_link];
    end else if (addr_off == lmc_pkg::TERM_OFF) begin
      rdata_next = term_q[addr_link];
    end else if (addr_off == lmc_pkg::SYS_OFF) begin
      rdata_next = sys_q[addr_link];
    end else if (addr_off == lmc_pkg::TEST_OFF) begin
      rdata_next = test_q[addr_link];
    end
  end

  // Read data loaded into a flop each cycle the read strobe is active, held once it ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rdata <= 8'h00;
    end else if (rd_act) begin
      host_rdata <= rdata_next;
    end
  end

  // Drive the data bus only during a read
  assign host_rdata_oe = rd_act;

endmodule

`default_nettype wire

// file: lmc_asserts.sv
// Assertion checker for the link mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module lmc_asserts #(
  parameter int NLINK = 8
) (
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               host_cs_n,
  input wire logic               host_rd_n,
  input wire logic               host_rdata_oe,
  input wire logic [2*NLINK-1:0] link_std,
  input wire logic [2*NLINK-1:0] link_fmt,
  input wire logic [2*NLINK-1:0] link_hdlc_cnt,
  input wire logic [2*NLINK-1:0] link_line_code,
  input wire logic [NLINK-1:0]   link_bpv_en,
  input wire logic [NLINK-1:0]   link_term_int_en,
  input wire logic [2*NLINK-1:0] link_term_sel,
  input wire logic [NLINK-1:0]   link_rate_conv
);
  logic [1:0] up_reg; // Cycles since reset release, saturating
  // Give the decoded outputs three edges to settle after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || up_reg != 2'h3);
  // Read strobe low, or chip select high, long enough to pass the synchronisers
  sequence rd_low; (!host_cs_n && !host_rd_n)[*4]; endsequence
  sequence cs_high; host_cs_n[*4]; endsequence
  read_oe_on_a: assert property (rd_low |-> host_rdata_oe) else $error("read enable missing");
  read_oe_off_a: assert property (cs_high |-> !host_rdata_oe) else $error("read enable stuck");
  // Decode relations, one set per link
  for (genvar i = 0; i < NLINK; i++) begin : g_link
    e1_fmt_zero_a: assert property (link_std[2*i+:2] == lmc_pkg::STD_E1 |-> link_fmt[2*i+:2] == 2'h0)
      else $error("format not ignored in European mode");
    e1_hdb3_a: assert property (link_std[2*i+:2] == lmc_pkg::STD_E1 |-> link_line_code[2*i+:2] == lmc_pkg::CODE_HDB3)
      else $error("line code wrong in European mode");
    hdlc_count_a: assert property (link_hdlc_cnt[2*i+:2] == ((link_std[2*i+:2] == lmc_pkg::STD_E1
      || link_fmt[2*i+:2] == lmc_pkg::FMT_ESF || link_fmt[2*i+:2] == lmc_pkg::FMT_DM) ? 2'h3 : 2'h2))
      else $error("HDLC channel count wrong");
    j1_fmt_limit_a: assert property (link_std[2*i+:2] == lmc_pkg::STD_J1 |-> !link_fmt[2*i+1])
      else $error("Japanese variant with reserved format");
    bpv_ami_only_a: assert property (link_bpv_en[i] |-> link_line_code[2*i+:2] == lmc_pkg::CODE_AMI)
      else $error("violation insertion without AMI");
    ext_term_sel_a: assert property (!link_term_int_en[i] |-> link_term_sel[2*i+:2] == 2'h0)
      else $error("termination select with matching off");
    e1_no_rate_a: assert property (link_std[2*i+:2] == lmc_pkg::STD_E1 |-> !link_rate_conv[i])
      else $error("rate conversion in European mode");
  end
endmodule
bind lmc_link_mode_config lmc_asserts #(.NLINK(NLINK)) u_chk (.ref_clk, .sys_rst, .host_cs_n, .host_rd_n,
  .host_rdata_oe, .link_std, .link_fmt, .link_hdlc_cnt, .link_line_code, .link_bpv_en, .link_term_int_en,
  .link_term_sel, .link_rate_conv);
`default_nettype wire

// file: lmc_host_model.sv
// Host processor model on the asynchronous parallel register port
`timescale 1ns/1ps
`default_nettype none
module lmc_host_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  host_rdata,
  output logic             host_cs_n,
  output logic             host_wr_n,
  output logic             host_rd_n,
  output logic      [10:0] host_addr,
  output logic      [7:0]  host_wdata
);
  // Bus idle from time zero
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_addr = 11'h000;
    host_wdata = 8'h00;
  end
  // One access: strobe low five cycles, then idle four; lines move on the falling edge
  task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = d;
    host_cs_n = 1'b0;
    host_wr_n = !wr;
    host_rd_n = wr;
    repeat (5) @(negedge ref_clk);
    q = host_rdata;
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    // Released lines must not keep their last value
    host_addr = ~a;
    host_wdata = ~d;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the link mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk;       // Device clock
  logic        sys_rst;       // Reset
  wire         cs_n, wr_n, rd_n, oe;
  wire  [10:0] addr;
  wire  [7:0]  wdata, rdata;
  wire  [15:0] std, fmt, hdlc, code, tsel;
  wire  [7:0]  unfr, bpv, pen, pdir, tint, rate, mux;
  wire  [23:0] lb;
  int          failures;      // Mismatches
  int          total_checks;  // Comparisons
  lmc_host_model HOST (.ref_clk, .host_rdata(rdata), .host_cs_n(cs_n), .host_wr_n(wr_n), .host_rd_n(rd_n),
    .host_addr(addr), .host_wdata(wdata));
  lmc_link_mode_config DUT (.ref_clk, .sys_rst, .host_cs_n(cs_n), .host_wr_n(wr_n), .host_rd_n(rd_n),
    .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rdata_oe(oe), .link_std(std),
    .link_fmt(fmt), .link_unframed(unfr), .link_hdlc_cnt(hdlc), .link_line_code(code), .link_bpv_en(bpv),
    .link_prbs_en(pen), .link_prbs_dir(pdir), .link_loopback(lb), .link_term_int_en(tint),
    .link_term_sel(tsel), .link_rate_conv(rate), .link_bus_mux(mux));
  // Compare and count
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    logic [7:0] q;
    HOST.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] q;
    HOST.access(1'b0, a, 8'h00, q);
    check("readback", q, e);
  endtask
  task automatic t_reset;
    rd(11'h020, 8'h00);
    for (int l = 0; l < 8; l++) begin
      check("std", std[2*l+:2], 2'h0);
      check("code", code[2*l+:2], lmc_pkg::CODE_HDB3);
      check("hdlc", hdlc[2*l+:2], 2'h3);
      check("term_en", tint[l], 1'b1);
    end
    $display("test reset done");
  endtask
  task automatic t_formats;
    for (int f = 0; f < 4; f++) begin
      wr(11'h320, 8'h08 | f[7:0]);
      rd(11'h320, 8'h08 | f[7:0]);
      check("std", std[7:6], lmc_pkg::STD_T1);
      check("fmt", fmt[7:6], f[1:0]);
      check("hdlc", hdlc[7:6], (f == 1 || f == 2) ? 2'h3 : 2'h2);
      check("code", code[7:6], lmc_pkg::CODE_B8ZS);
      check("other", std[5:4], 2'h0);
    end
    wr(11'h520, 8'h0D);
    check("j1", {std[11:10], fmt[11:10]}, 4'h9);
    wr(11'h520, 8'h0E);
    rd(11'h520, 8'h0D);
    check("j1", {std[11:10], fmt[11:10]}, 4'h9);
    wr(11'h120, 8'h07);
    rd(11'h120, 8'h07);
    check("e1", {std[3:2], fmt[3:2]}, 4'h0);
    $display("test formats done");
  endtask
  task automatic t_term;
    for (int v = 0; v < 8; v++) begin
      wr(11'h032, v[7:0]);
      rd(11'h032, v[7:0]);
      check("term_en", tint[0], !v[2]);
      check("term_sel", tsel[1:0], v[2] ? 2'h0 : v[1:0]);
    end
    $display("test termination done");
  endtask
  task automatic t_sys;
    wr(11'h720, 8'h08);
    wr(11'h740, 8'h03);
    check("rate", rate[7], 1'b1);
    check("mux", mux[7], 1'b1);
    wr(11'h720, 8'h00);
    check("rate", rate[7], 1'b0);
    check("mux", mux[7], 1'b1);
    $display("test system done");
  endtask
  task automatic t_test;
    wr(11'h720, 8'h08);
    wr(11'h741, 8'h07);
    check("unframed", unfr[7], 1'b1);
    check("code", code[15:14], lmc_pkg::CODE_AMI);
    check("bpv", bpv[7], 1'b1);
    wr(11'h741, 8'h1D);
    check("bpv", bpv[7], 1'b0);
    check("prbs", {pen[7], pdir[7]}, 2'h3);
    for (int m = 0; m < 8; m++) begin
      wr(11'h741, m[7:0] << 5);
      check("loop", lb[23:21], (m == 7) ? 3'h0 : m[2:0]);
    end
    rd(11'h055, 8'h00);
    rd(11'h7FF, 8'h00);
    $display("test diagnostics done");
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_formats();
    t_term();
    t_sys();
    t_test();
    print_verdict();
  end
endmodule
`default_nettype wire
